// File: hw/adccp_cfg.svh
// Timing counts and field widths for the converter control block.
// Assumes the includer runs on clk_sys at 125 MHz.
`ifndef ADCCP_CFG_SVH
`define ADCCP_CFG_SVH
`define ADCCP_CLK_MHZ      125
`define ADCCP_ACQ_NS       250
`define ADCCP_ACQ_CYC      ((`ADCCP_ACQ_NS * `ADCCP_CLK_MHZ + 999) / 1000)
`define ADCCP_CONV_NS      1000
`define ADCCP_CONV_CYC     ((`ADCCP_CONV_NS * `ADCCP_CLK_MHZ + 999) / 1000)
`define ADCCP_CNT_W        8
`define ADCCP_DATA_W       16
`define ADCCP_RESULT_RST   16'h0000
`endif

// File: hw/adccp_pkg.sv
// Types shared by the converter control block.
// Assumes adccp_cfg.svh is on the include path.
`include "adccp_cfg.svh"
package adccp_pkg;
	typedef enum logic [1:0]
	{
		ST_ACQ  = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10,
		ST_DOWN = 2'b11
	} adccp_state_t;

	typedef struct packed
	{
		logic internalRefOn;
		logic refBufferOn;
	} adccp_ref_t;
endpackage

// File: hw/adccp_sync2.sv
// Two flip-flop synchroniser for one asynchronous pin.
// Assumes a synchronous active-high reset and a shared clock enable.
`timescale 1ns/100ps
module adccp_sync2
#(
	parameter logic RST_VAL = 1'b0
)
(
	// Clock and control
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic clkEn,
	// Data
	input  wire logic pinIn,
	output logic      syncOut
);
	logic stage1;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			stage1  <= RST_VAL;
			syncOut <= RST_VAL;
		end
		else if (clkEn)
		begin
			stage1  <= pinIn;
			syncOut <= stage1;
		end
	end
endmodule

// File: hw/adccp_top.sv
// Control logic for the digital pins of a sampling converter.
// Assumes host strobes arrive asynchronously; the core runs on clk_sys.
// Summary of operation
// - Output bus enabled only when read, select low
// - Select high blocks external serial clock edges
// - Reset high aborts conversion, resets device
// - Power down finishes conversion, then blocks starts
// - Start high at acquisition end awaits fall
// - Start low at acquisition end converts immediately
// - Reference off pin disables on-chip reference
// - Buffer off pin disables reference buffer
// - Busy high from start until result latched
`timescale 1ns/100ps
`include "adccp_cfg.svh"
module adccp_top
#(
	parameter int ACQ_CYC  = `ADCCP_ACQ_CYC,
	parameter int CONV_CYC = `ADCCP_CONV_CYC,
	parameter int DATA_W   = `ADCCP_DATA_W
)
(
	// Clock, reset and enable
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              clkEn,
	// Host pins
	input  wire logic              convert_start_n,
	input  wire logic              power_down,
	input  wire logic              read_n,
	input  wire logic              select_n,
	input  wire logic              extSerialClk,
	input  wire logic              internal_ref_off,
	input  wire logic              ref_buffer_off,
	// Converter core
	input  wire logic [DATA_W-1:0] coreResult,
	// Outputs to host
	output logic                   busy,
	output logic                   outputEnable,
	output logic                   serialClkEdge,
	output logic [DATA_W-1:0]      resultShift,
	// Analog control
	output logic                   sampleHold,
	output logic                   lowPower,
	output adccp_pkg::adccp_ref_t  refCtrl
);
	localparam int SYN_N = 7;

	logic [SYN_N-1:0] pinsRaw;
	logic [SYN_N-1:0] pinsSync;
	logic             startN;
	logic             powerDown;
	logic             readN;
	logic             selectN;
	logic             sclk;
	logic             refOff;
	logic             bufOff;
	logic             startPrev;
	logic             sclkPrev;
	logic [`ADCCP_CNT_W-1:0] count;
	logic [`ADCCP_CNT_W-1:0] next_count;
	adccp_pkg::adccp_state_t state;
	adccp_pkg::adccp_state_t next_state;

	assign pinsRaw = {convert_start_n, power_down, read_n, select_n,
		extSerialClk, internal_ref_off, ref_buffer_off};

	////////////////////////////////////////////////////////////////////////
	// Every host pin passes two flip-flops.
	genvar gi;
	generate
		for (gi = 0; gi < SYN_N; gi++)
		begin : gSync
			adccp_sync2 #(.RST_VAL(gi == SYN_N-1 || gi == 4 || gi == 3)) uSync
			(
				.clk_sys (clk_sys),
				.rst     (rst),
				.clkEn   (clkEn),
				.pinIn   (pinsRaw[gi]),
				.syncOut (pinsSync[gi])
			);
		end
	endgenerate

	assign {startN, powerDown, readN, selectN, sclk, refOff, bufOff} =
		pinsSync;

	////////////////////////////////////////////////////////////////////////
	// Decoding of the strobes.
	wire startFall = startPrev & ~startN;
	wire acqDone   = (count == 8'(ACQ_CYC - 1));
	wire convDone  = (count == 8'(CONV_CYC - 1));
	wire sclkRise  = sclk & ~sclkPrev;

	assign outputEnable  = ~readN & ~selectN;
	assign serialClkEdge = sclkRise & ~selectN;
	assign refCtrl.internalRefOn = ~refOff;
	assign refCtrl.refBufferOn   = ~bufOff;

	////////////////////////////////////////////////////////////////////////
	// Acquisition and conversion sequencer.
	always_comb
	begin
		next_state = state;
		next_count = count + 8'h01;
		case (state)
			adccp_pkg::ST_ACQ:
			begin
				if (acqDone)
				begin
					next_count = 8'h00;
					if (powerDown)
						next_state = adccp_pkg::ST_DOWN;
					else if (!startN)
						next_state = adccp_pkg::ST_CONV;
					else
						next_state = adccp_pkg::ST_WAIT;
				end
			end
			adccp_pkg::ST_WAIT:
			begin
				next_count = 8'h00;
				if (powerDown)
					next_state = adccp_pkg::ST_DOWN;
				else if (startFall)
					next_state = adccp_pkg::ST_CONV;
			end
			adccp_pkg::ST_CONV:
			begin
				if (convDone)
				begin
					next_count = 8'h00;
					next_state = adccp_pkg::ST_ACQ;
				end
			end
			adccp_pkg::ST_DOWN:
			begin
				next_count = 8'h00;
				if (!powerDown)
					next_state = adccp_pkg::ST_ACQ;
			end
			default:
			begin
				next_count = 8'h00;
				next_state = adccp_pkg::ST_ACQ;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state     <= adccp_pkg::ST_ACQ;
			count     <= 8'h00;
			startPrev <= 1'b1;
			sclkPrev  <= 1'b0;
		end
		else if (clkEn)
		begin
			state     <= next_state;
			count     <= next_count;
			startPrev <= startN;
			sclkPrev  <= sclk;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			resultShift <= `ADCCP_RESULT_RST;
		else if (clkEn && state == adccp_pkg::ST_CONV && convDone)
			resultShift <= coreResult;
	end

	assign busy       = (state == adccp_pkg::ST_CONV);
	assign sampleHold = busy;
	assign lowPower   = (state == adccp_pkg::ST_DOWN);

	////////////////////////////////////////////////////////////////////////
	// Checks.
	a_bus_enable: assert property (
		@(posedge clk_sys) disable iff (rst)
		outputEnable == (!readN && !selectN))
		else $error("output bus enable wrong");
	a_sclk_gate: assert property (
		@(posedge clk_sys) disable iff (rst)
		selectN |-> !serialClkEdge)
		else $error("serial clock passed while deselected");
	a_reset_abort: assert property (
		@(posedge clk_sys)
		rst |=> !busy && state == adccp_pkg::ST_ACQ)
		else $error("reset did not abort conversion");
	a_reset_resume: assert property (
		@(posedge clk_sys)
		$fell(rst) |-> !busy && state == adccp_pkg::ST_ACQ
		&& count == 8'h00)
		else $error("acquisition did not restart after reset");
	a_pd_finish: assert property (
		@(posedge clk_sys) disable iff (rst)
		(busy && clkEn && !convDone) |=> busy)
		else $error("conversion cut short");
	a_pd_block: assert property (
		@(posedge clk_sys) disable iff (rst)
		(lowPower && powerDown) |=> !busy)
		else $error("conversion started in power down");
	a_wait_edge: assert property (
		@(posedge clk_sys) disable iff (rst)
		(state == adccp_pkg::ST_WAIT && clkEn && startFall && !powerDown)
		|=> busy)
		else $error("falling edge did not start conversion");
	a_wait_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		(state == adccp_pkg::ST_WAIT && !startFall) |=> !busy)
		else $error("conversion started without a falling edge");
	a_imm_start: assert property (
		@(posedge clk_sys) disable iff (rst)
		(state == adccp_pkg::ST_ACQ && acqDone && clkEn && !startN
		&& !powerDown) |=> busy)
		else $error("low start did not convert at once");
	a_ref_ctrl: assert property (
		@(posedge clk_sys) disable iff (rst)
		refCtrl.internalRefOn != refOff && refCtrl.refBufferOn != bufOff)
		else $error("reference control wrong");
	a_busy_latch: assert property (
		@(posedge clk_sys) disable iff (rst)
		(busy && clkEn && convDone) |=> !busy
		&& resultShift == $past(coreResult))
		else $error("busy fell without result latched");
endmodule

// File: tb/adccp_host_model.sv
// Host model that drives the conversion start pin.
// Assumes requests arrive just after a falling edge.
`timescale 1ns/100ps
module adccp_host_model
(
	// Clock
	input  wire logic clk_sys,
	// Bench requests
	input  wire logic pulseReq,
	input  wire logic holdLow,
	// Device pin
	output logic      convert_start_n
);
	logic [2:0] pulseCnt = 3'h0;
	// A request gives one clean low pulse of four cycles.
	always @(negedge clk_sys)
		pulseCnt <= pulseReq ? 3'h4 : pulseCnt - (pulseCnt != 3'h0);
	assign convert_start_n = !(holdLow || pulseCnt != 3'h0);
endmodule

// File: tb/adccp_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes short acquisition and conversion counts.
`timescale 1ns/100ps
module adccp_tb_top;
	localparam int ACQ = 4;
	localparam int CONV = 6;
	logic clk_sys = 1'b0, rst = 1'b1, pulseReq = 1'b0, holdLow = 1'b0;
	logic clkEn = 1'b1;
	logic power_down = 1'b0, read_n = 1'b1, select_n = 1'b1;
	logic extSerialClk = 1'b0, internal_ref_off = 1'b0;
	logic ref_buffer_off = 1'b0, convert_start_n, busy, outputEnable;
	logic serialClkEdge, sampleHold, lowPower;
	logic [15:0] coreResult = 16'h0000, resultShift;
	logic [15:0] expQ[$];
	adccp_pkg::adccp_ref_t refCtrl;
	int fails = 0, total_checks = 0, edges = 0, busyLen = 0, base;
	adccp_host_model u_adccp_host_model (.clk_sys(clk_sys),
		.pulseReq(pulseReq), .holdLow(holdLow),
		.convert_start_n(convert_start_n));
	adccp_top #(.ACQ_CYC(ACQ), .CONV_CYC(CONV), .DATA_W(16)) u_adccp_top (
		.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
		.convert_start_n(convert_start_n), .power_down(power_down),
		.read_n(read_n), .select_n(select_n), .extSerialClk(extSerialClk),
		.internal_ref_off(internal_ref_off), .ref_buffer_off(ref_buffer_off),
		.coreResult(coreResult), .busy(busy), .outputEnable(outputEnable),
		.serialClkEdge(serialClkEdge), .resultShift(resultShift),
		.sampleHold(sampleHold), .lowPower(lowPower), .refCtrl(refCtrl));
	initial
		forever #4 clk_sys = ~clk_sys;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic waitBusy(input logic lvl);
		for (int n = 0; n < 100 && busy !== lvl; n++)
			@(negedge clk_sys);
		chk(busy, lvl);
		chk(sampleHold, lvl);
	endtask
	task automatic startPulse();
		pulseReq <= 1'b1;
		@(negedge clk_sys);
		pulseReq <= 1'b0;
		waitBusy(1'b1);
	endtask
	// Each falling busy outside reset pops the oldest expected result.
	always @(negedge clk_sys)
	begin
		busyLen <= busy ? busyLen + 1 : 0;
		edges <= edges + serialClkEdge;
		if (busyLen != 0 && !busy && !rst)
		begin
			chk(expQ.size() != 0, 1'b1);
			if (expQ.size() != 0)
				chk(resultShift, expQ.pop_front());
			chk(busyLen, CONV);
		end
	end
	initial
	begin
		#20000;
		fails++;
		tally_and_finish();
	end
	initial
	begin
		coreResult = 16'($urandom(98));
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			{internal_ref_off, ref_buffer_off} = i[1:0];
			{read_n, select_n} = i[1:0];
			repeat (4) @(negedge clk_sys);
			chk(refCtrl, {~i[1], ~i[0]});
			chk(outputEnable, i == 0);
		end
		// With the clock enable low the pin change must not reach the core.
		clkEn = 1'b0;
		internal_ref_off = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(refCtrl, 2'b00);
		clkEn = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk(refCtrl, 2'b10);
		for (int s = 0; s < 2; s++)
		begin
			select_n = !s[0];
			repeat (3) @(negedge clk_sys);
			base = edges;
			repeat (5)
			begin
				extSerialClk = 1'b1;
				repeat (3) @(negedge clk_sys);
				extSerialClk = 1'b0;
				repeat (3) @(negedge clk_sys);
			end
			chk(edges - base, s * 5);
		end
		for (int k = 0; k < 3; k++)
		begin
			chk(busy, 1'b0);
			coreResult = 16'($urandom);
			expQ.push_back(coreResult);
			startPulse();
			waitBusy(1'b0);
			repeat (ACQ + 4) @(negedge clk_sys);
		end
		expQ.push_back(coreResult);
		expQ.push_back(coreResult);
		holdLow = 1'b1;
		waitBusy(1'b1);
		waitBusy(1'b0);
		waitBusy(1'b1);
		holdLow = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(busy, 1'b0);
		chk(resultShift, 16'h0000);
		// The aborted conversion leaves no result behind.
		expQ.delete();
		rst = 1'b0;
		repeat (ACQ + 4) @(negedge clk_sys);
		coreResult = 16'($urandom);
		expQ.push_back(coreResult);
		startPulse();
		power_down = 1'b1;
		waitBusy(1'b0);
		repeat (ACQ + 4) @(negedge clk_sys);
		chk(lowPower, 1'b1);
		pulseReq <= 1'b1;
		@(negedge clk_sys);
		pulseReq <= 1'b0;
		repeat (20) @(negedge clk_sys);
		chk(busy, 1'b0);
		chk(expQ.size(), 0);
		tally_and_finish();
	end
endmodule
